// [hdl/trip_reset_and_thermal_trip.sv]
// Reset terminal and thermistor trip control of a motor drive
module trip_reset_and_thermal_trip
   import trip_reset_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Intelligent input pins, active high
   input wire logic [N_TERM-1:0] terminal_i,
   // Terminal function assignment
   input wire logic [7:0] clr_term_opt_i,
   input wire logic [2:0] clr_term_sel_i,
   input wire logic [7:0] term5_opt_i,
   // Thermistor comparator pins
   input wire logic therm_hot_i,
   input wire logic therm_open_i,
   // Operator pins
   input wire logic run_cmd_i,
   input wire logic stop_key_i,
   input wire logic remote_attached_i,
   // Logic output requests and OFF delay settings
   input wire logic [N_LOUT-1:0] lout_req_i,
   input wire logic [N_LOUT-1:0] lout_delay_en_i,
   // Drive control
   output logic motor_enable_o,
   output logic coast_o,
   output logic system_reset_o,
   // Status
   output logic [N_LOUT-1:0] lout_o,
   output logic alarm_o,
   output logic trip_mode_o,
   output logic [7:0] trip_code_o,
   output logic display_alt_o,
   output logic key_window_o
);
   typedef struct packed {
      seq_state_t st;
      logic [4:0] qual_ms;
      logic [11:0] up_ms;
      logic [N_LOUT-1:0][9:0] hold_ms;
      logic [N_LOUT-1:0] lout;
      logic trip;
      logic [7:0] trip_code;
      logic alarm;
      logic motor_en;
      logic coast;
      logic sys_reset;
      logic disp_alt;
      logic key_window;
      logic key_prev;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;

   logic [N_TERM-1:0] term_s;
   logic hot_s;
   logic open_s;
   logic run_s;
   logic key_s;
   logic remote_s;
   logic tick;

   // All pins pass two flops before use
   input_sync #(.WIDTH(N_TERM + 5)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .pin_i({terminal_i, therm_hot_i, therm_open_i, run_cmd_i, stop_key_i, remote_attached_i}),
      .level_o({term_s, hot_s, open_s, run_s, key_s, remote_s})
   );

   ms_tick #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   // Decoded terminal functions and operator events
   logic therm_en;
   logic clr_fn_en;
   logic clr_sel_ok;
   logic clr_on;
   logic therm_fault;
   logic key_press;
   logic key_ok;
   logic key_clear_ok;

   // Sequencer strobes
   logic qual_done;
   logic clr_qualified;
   logic trip_set;
   logic trip_clr;

   // Per-output OFF-delay status
   logic [N_LOUT-1:0] hold_active;
   logic [N_LOUT-1:0] hold_done;

   // Thermistor function lives only on terminal 5
   assign therm_en = (term5_opt_i == OPT_THERM_FN);

   // An index past the last terminal selects nothing rather than an unknown bit
   assign clr_sel_ok = (clr_term_sel_i < 3'(N_TERM));

   // Reset function needs its option code and loses terminal 5 to the thermistor
   assign clr_fn_en = (clr_term_opt_i == OPT_RESET_FN) && clr_sel_ok
      && !(therm_en && clr_term_sel_i == THERM_TERM_IDX);

   // No polarity inversion is offered: pin high always means ON
   assign clr_on = clr_fn_en && term_s[clr_term_sel_i];

   // Over-temperature and open circuit share one trip cause
   assign therm_fault = therm_en && (hot_s || open_s);

   // Key press is the rising edge of the synchronised key level
   assign key_press = key_s && !s.key_prev;

   // A remote operator restricts the key to the power-up window
   assign key_ok = !remote_s || s.key_window;

   // Key clears only once the sensor reads cool and closed again
   assign key_clear_ok = key_press && key_ok && !hot_s && !open_s;

   // Enough whole ticks seen; one spare tick hides the unknown tick phase
   assign qual_done = (s.qual_ms >= CLR_QUAL_TICKS);

   // Per-output hold flags for the OFF-delay extension
   generate
      for (genvar g = 0; g < N_LOUT; g++) begin : g_hold
         // Hold applies only to an output that was on and has a delay set
         assign hold_active[g] = lout_delay_en_i[g] && s.lout[g];
         // Saturated count marks the end of the extra second
         assign hold_done[g] = (s.hold_ms[g] == OFF_HOLD_TICKS);
      end
   endgenerate

   // Sequencer, trip flag and outputs
   always_comb begin
      next_s = s;
      // Strobe defaults low every cycle
      clr_qualified = 1'b0;
      next_s.key_prev = key_s;

      // Power-up timer; saturates so the window never reopens
      if (tick && s.up_ms != KEY_WINDOW_TICKS) begin
         next_s.up_ms = s.up_ms + 12'h001;
      end

      // Window closes in the cycle the timer saturates
      next_s.key_window = (next_s.up_ms != KEY_WINDOW_TICKS);

      unique case (s.st)
         // Power-on behaves like a held reset of minimum width
         ST_POWERUP: begin
            next_s.sys_reset = 1'b1;
            // Same qualification count as a terminal pulse
            if (tick) begin
               next_s.qual_ms = s.qual_ms + 5'h01;
            end
            if (qual_done) begin
               next_s.st = ST_RUN;
               next_s.qual_ms = 5'h00;
               next_s.sys_reset = 1'b0;
            end
         end

         // Normal operation; any ON level starts qualification
         ST_RUN: begin
            next_s.sys_reset = 1'b0;
            next_s.qual_ms = 5'h00;
            if (clr_on) begin
               next_s.st = ST_CLR_WAIT;
            end
         end

         // Qualify width; a glitch stops the motor and drops undelayed outputs, never clears a trip
         ST_CLR_WAIT: begin
            if (!clr_on) begin
               next_s.st = ST_RUN;
               next_s.qual_ms = 5'h00;
            end else begin
               if (tick) begin
                  next_s.qual_ms = s.qual_ms + 5'h01;
               end
               if (qual_done) begin
                  clr_qualified = 1'b1;
                  next_s.st = ST_CLR_HELD;
                  next_s.sys_reset = 1'b1;
               end
            end
         end

         // Reset stays applied until the terminal is released
         ST_CLR_HELD: begin
            next_s.sys_reset = 1'b1;
            // Release ends the reset; the motor may restart at once
            if (!clr_on) begin
               next_s.st = ST_RUN;
               next_s.sys_reset = 1'b0;
               next_s.qual_ms = 5'h00;
            end
         end
      endcase

      // Trip flag: a fault present in the clearing cycle wins
      trip_set = therm_fault;
      // Clear sources: a qualified reset pulse or an accepted key press
      trip_clr = clr_qualified
         || key_clear_ok;
      next_s.trip = (s.trip && !trip_clr) || trip_set;

      // Code follows the flag; an open circuit reports the same code
      if (trip_set) begin
         next_s.trip_code = TRIP_CODE_THERM;
      end else if (trip_clr) begin
         next_s.trip_code = TRIP_CODE_NONE;
      end

      // Alarm cleared at qualification, well inside ALARM_CLEAR_MAX_MS
      next_s.alarm = next_s.trip;

      // Motor runs only in normal operation with run asserted; a held run restarts it
      next_s.motor_en = run_s && !next_s.trip && !clr_on && (next_s.st == ST_RUN);

      // Coast flag marks drive removed from a running motor; no ramp is applied
      if (clr_on && s.motor_en) begin
         next_s.coast = 1'b1;
      end else if (!clr_on) begin
         // A stopped motor never sets it; release always clears it
         next_s.coast = 1'b0;
      end

      // Display pattern tracks the terminal and the power-on reset
      next_s.disp_alt = clr_on || next_s.st == ST_POWERUP;

      // Per-output OFF-delay hold; outputs without delay drop at once
      for (int i = 0; i < N_LOUT; i++) begin
         if (clr_on) begin
            if (hold_active[i] && !hold_done[i]) begin
               next_s.lout[i] = 1'b1;
               if (tick) begin
                  next_s.hold_ms[i] = s.hold_ms[i] + 10'h001;
               end
            end else begin
               next_s.lout[i] = 1'b0;
            end
         end else begin
            // Outputs return to their requests once the terminal is OFF and no system reset is applied
            next_s.hold_ms[i] = 10'h000;
            next_s.lout[i] = lout_req_i[i] && !next_s.sys_reset;
         end
      end
   end

   // Single state register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.st <= ST_POWERUP;
         s.sys_reset <= 1'b1;
         s.disp_alt <= 1'b1;
         s.key_window <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Drive control straight from the state register
   assign motor_enable_o = s.motor_en;
   assign coast_o = s.coast;
   assign system_reset_o = s.sys_reset;

   // Status straight from the state register
   assign lout_o = s.lout;
   assign alarm_o = s.alarm;
   assign trip_mode_o = s.trip;
   assign trip_code_o = s.trip_code;

   // Operator panel indications
   assign display_alt_o = s.disp_alt;
   assign key_window_o = s.key_window;
endmodule

// [hdl/trip_reset_pkg.sv]
// Constants shared by the trip, reset and thermistor control logic
package trip_reset_pkg;
   // System clock and the millisecond tick
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // Times in milliseconds, as specified
   localparam int CLR_MIN_MS = 12;
   localparam int ALARM_CLEAR_MAX_MS = 30;
   localparam int OFF_DELAY_HOLD_MS = 1000;
   localparam int KEY_WINDOW_MS = 3000;
   // Times converted to tick counts; only the reset qualification count gets one extra tick for the unknown tick phase
   localparam logic [4:0] CLR_QUAL_TICKS = 5'(CLR_MIN_MS / TICK_MS + 1);
   localparam logic [9:0] OFF_HOLD_TICKS = 10'(OFF_DELAY_HOLD_MS / TICK_MS);
   localparam logic [11:0] KEY_WINDOW_TICKS = 12'(KEY_WINDOW_MS / TICK_MS);
   // Terminal functions and trip codes
   localparam logic [7:0] OPT_RESET_FN = 8'h12;
   localparam logic [7:0] OPT_THERM_FN = 8'h13;
   localparam logic [2:0] THERM_TERM_IDX = 3'h4;
   localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
   localparam logic [7:0] TRIP_CODE_THERM = 8'h23;
   // Widths
   localparam int N_TERM = 7;
   localparam int N_LOUT = 3;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_POWERUP = 4'h1,
      ST_RUN     = 4'h2,
      ST_CLR_WAIT = 4'h4,
      ST_CLR_HELD = 4'h8
   } seq_state_t;
endpackage

// [hdl/input_sync.sv]
// Two-flop synchroniser for a group of pin inputs
module input_sync
   import trip_reset_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] level;
   } sync_t;

   sync_t s;
   sync_t next_s;

   // First stage feeds only the second
   always_comb begin
      next_s = s;
      next_s.meta = pin_i;
      next_s.level = s.meta;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level_o = s.level;
endmodule

// [hdl/ms_tick.sv]
// Millisecond tick generator from the system clock
module ms_tick
   import trip_reset_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // One-cycle pulse every tick period
   output logic tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t s;
   tick_state_t next_s;

   // Free-running divider
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == 16'(TICK_CYCLES_P - 1)) begin
         next_s.cnt = 16'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_o = s.tick;
endmodule

// [testbench/trip_reset_checker.sv]
// Port checker for the reset terminal and thermistor trip block
module trip_reset_checker
   import trip_reset_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Watched inputs
   input wire logic [N_TERM-1:0] terminal_i,
   input wire logic [7:0] clr_term_opt_i,
   input wire logic [2:0] clr_term_sel_i,
   input wire logic [7:0] term5_opt_i,
   input wire logic therm_hot_i,
   input wire logic [N_LOUT-1:0] lout_delay_en_i,
   // Watched outputs
   input wire logic motor_enable_o,
   input wire logic coast_o,
   input wire logic system_reset_o,
   input wire logic [N_LOUT-1:0] lout_o,
   input wire logic alarm_o,
   input wire logic trip_mode_o,
   input wire logic [7:0] trip_code_o,
   input wire logic display_alt_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   localparam int ALARM_LIM = ALARM_CLEAR_MAX_MS * TICK_CYCLES_P + 3;
   // Reset function level as decoded from the option settings
   wire logic clr_pin = terminal_i[clr_term_sel_i] && clr_term_opt_i == OPT_RESET_FN
      && !(term5_opt_i == OPT_THERM_FN && clr_term_sel_i == THERM_TERM_IDX);
   // Cycles the pin has been held; saturates to keep it small
   int clr_cnt;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || !clr_pin) clr_cnt <= 0;
      else if (clr_cnt <= ALARM_LIM) clr_cnt <= clr_cnt + 1;
   end
   a_clr_stops_motor: assert property ($rose(clr_pin) |-> ##3 !motor_enable_o && display_alt_o)
      else $error("reset did not stop motor");
   a_clr_no_delay: assert property ($rose(clr_pin) |-> ##3 (lout_o & ~lout_delay_en_i) == '0)
      else $error("undelayed output still on");
   a_coast_cause: assert property ($rose(coast_o) |-> $past(motor_enable_o) && !motor_enable_o)
      else $error("coast without running motor");
   a_code_match: assert property (trip_code_o == (trip_mode_o ? TRIP_CODE_THERM : TRIP_CODE_NONE))
      else $error("trip code wrong");
   a_trip_no_motor: assert property (trip_mode_o |-> !motor_enable_o && alarm_o)
      else $error("motor on during trip");
   a_hot_trips: assert property ($rose(therm_hot_i) && term5_opt_i == OPT_THERM_FN |-> ##3 trip_mode_o)
      else $error("over-temperature did not trip");
   a_alarm_bound: assert property (clr_cnt > ALARM_LIM |-> !alarm_o)
      else $error("alarm not cleared in time");
   a_qual_width: assert property ($rose(system_reset_o) |-> clr_cnt >= CLR_MIN_MS * TICK_CYCLES_P)
      else $error("reset taken from short pulse");
   a_release_ends: assert property ($fell(clr_pin) |-> ##3 !system_reset_o && !coast_o)
      else $error("reset not released");
endmodule

bind trip_reset_and_thermal_trip trip_reset_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (.*);

// [testbench/terminal_driver.sv]
// Model of the switch or controller that drives the input terminals
module terminal_driver
   import trip_reset_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Terminal pins
   output logic [N_TERM-1:0] terminal_o
);
   initial terminal_o = '0;
   // Closes one normally-open contact for a number of clocks
   task automatic pulse(input int idx, input int len);
      @(negedge clk_sys_i) terminal_o[idx] = 1'b1;
      repeat (len) @(negedge clk_sys_i);
      terminal_o[idx] = 1'b0;
   endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the reset terminal and thermistor trip block
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench
   import trip_reset_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 10;
   logic clk_sys_i, rst_n_i;
   logic [N_TERM-1:0] terminal_i;
   logic [7:0] clr_term_opt_i, term5_opt_i, trip_code_o;
   logic [2:0] clr_term_sel_i;
   logic therm_hot_i, therm_open_i, run_cmd_i, stop_key_i, remote_attached_i;
   logic [N_LOUT-1:0] lout_req_i, lout_delay_en_i, lout_o;
   logic motor_enable_o, coast_o, system_reset_o, alarm_o, trip_mode_o, display_alt_o, key_window_o;
   int fail_count, n_checks;
   // Short tick keeps the ms figures affordable
   trip_reset_and_thermal_trip #(.TICK_CYCLES_P(TK)) dut (.*);
   terminal_driver tm (.clk_sys_i(clk_sys_i), .terminal_o(terminal_i));
   // 40 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bounded wait; a miss ends the run
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         step(1);
         n++;
      end
      if (s !== v) begin
         fail_count++;
         $display("mismatch wait expected %0h seen %0h", v, s);
         final_report();
      end
   endtask
   // Let fault levels settle before the key edge
   task automatic press_key();
      step(3);
      stop_key_i = 1'b1;
      step(4);
      stop_key_i = 1'b0;
      step(2);
   endtask
   task automatic make_trip();
      therm_hot_i = 1'b1;
      step(4);
      therm_hot_i = 1'b0;
      step(1);
   endtask
   task automatic t_power_up();
      `CHK("sysrst", 1'b1, system_reset_o)
      `CHK("window", 1'b1, key_window_o)
      wait_lvl(system_reset_o, 1'b0, 200);
      step(4);
      `CHK("motor", 1'b1, motor_enable_o)
      $display("test power_up done");
   endtask
   task automatic t_therm();
      for (int k = 0; k < 2; k++) begin
         if (k == 0) therm_hot_i = 1'b1;
         else therm_open_i = 1'b1;
         step(4);
         `CHK("trip", 1'b1, trip_mode_o)
         `CHK("code", TRIP_CODE_THERM, trip_code_o)
         `CHK("motor", 1'b0, motor_enable_o)
         therm_hot_i = 1'b0;
         therm_open_i = 1'b0;
         press_key();
         `CHK("trip", 1'b0, trip_mode_o)
      end
      $display("test therm done");
   endtask
   task automatic t_clr_run();
      fork tm.pulse(0, 10500); join_none
      step(5);
      `CHK("coast", 1'b1, coast_o)
      `CHK("disp", 1'b1, display_alt_o)
      `CHK("lout", 3'b100, lout_o)
      step(9600);
      `CHK("lout", 3'b100, lout_o)
      step(500);
      `CHK("lout", 3'b000, lout_o)
      `CHK("sysrst", 1'b1, system_reset_o)
      step(420);
      `CHK("sysrst", 1'b0, system_reset_o)
      `CHK("motor", 1'b1, motor_enable_o)
      `CHK("disp", 1'b0, display_alt_o)
      $display("test clr_run done");
   endtask
   task automatic t_clr_trip();
      make_trip();
      fork tm.pulse(0, 160); join_none
      wait_lvl(alarm_o, 1'b0, 305);
      `CHK("trip", 1'b0, trip_mode_o)
      step(170);
      `CHK("motor", 1'b1, motor_enable_o)
      $display("test clr_trip done");
   endtask
   task automatic t_short();
      make_trip();
      tm.pulse(0, 100);
      step(4);
      `CHK("trip", 1'b1, trip_mode_o)
      `CHK("sysrst", 1'b0, system_reset_o)
      press_key();
      $display("test short done");
   endtask
   task automatic t_no_fn();
      clr_term_opt_i = 8'h00;
      fork tm.pulse(0, 20); join_none
      step(6);
      `CHK("motor", 1'b1, motor_enable_o)
      step(20);
      clr_term_opt_i = OPT_RESET_FN;
      $display("test no_fn done");
   endtask
   // Thermistor only on terminal 5; reset function refused there
   task automatic t_term5();
      term5_opt_i = 8'h00;
      therm_hot_i = 1'b1;
      step(5);
      `CHK("trip", 1'b0, trip_mode_o)
      therm_hot_i = 1'b0;
      step(3);
      term5_opt_i = OPT_THERM_FN;
      clr_term_sel_i = 3'h4;
      fork tm.pulse(4, 20); join_none
      step(6);
      `CHK("motor", 1'b1, motor_enable_o)
      step(20);
      clr_term_sel_i = 3'h0;
      $display("test term5 done");
   endtask
   task automatic t_window();
      remote_attached_i = 1'b1;
      wait_lvl(key_window_o, 1'b0, 32000);
      make_trip();
      press_key();
      `CHK("trip", 1'b1, trip_mode_o)
      remote_attached_i = 1'b0;
      press_key();
      `CHK("trip", 1'b0, trip_mode_o)
      $display("test window done");
   endtask
   // Main sequence
   initial begin
      fail_count = 0;
      n_checks = 0;
      rst_n_i = 1'b0;
      clr_term_opt_i = OPT_RESET_FN;
      clr_term_sel_i = 3'h0;
      term5_opt_i = OPT_THERM_FN;
      therm_hot_i = 1'b0;
      therm_open_i = 1'b0;
      run_cmd_i = 1'b1;
      stop_key_i = 1'b0;
      remote_attached_i = 1'b0;
      lout_req_i = 3'b111;
      lout_delay_en_i = 3'b100;
      step(4);
      rst_n_i = 1'b1;
      t_power_up();
      t_therm();
      t_clr_run();
      t_clr_trip();
      t_short();
      t_no_fn();
      t_term5();
      t_window();
      final_report();
   end
endmodule
